// file: rtl/pin_sync.sv
// two-flop synchroniser with edge pulses for one asynchronous pin
// assumes the pin changes no faster than every two hclk cycles
`timescale 1ns/1ps
module pin_sync #(
	parameter logic RESET_LEVEL = 1'b1
) (
	input  wire logic hclk,     // bus clock
	input  wire logic hresetn,  // async reset, active low
	input  wire logic pin,      // raw asynchronous input
	output logic      level,    // synchronised level
	output logic      rise,     // one-cycle pulse on a rising edge
	output logic      fall      // one-cycle pulse on a falling edge
);

	logic meta;
	logic prev;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			meta  <= RESET_LEVEL;
			level <= RESET_LEVEL;
			prev  <= RESET_LEVEL;
		end else begin
			meta  <= pin;
			level <= meta;
			prev  <= level;
		end
	end

	assign rise = level && !prev;
	assign fall = !level && prev;

endmodule

// file: rtl/sync_serial_pkg.sv
// constants shared by the synchronous serial receive/duplex block
// assumes a 250 MHz bus clock and an AHB-Lite register window of 256 bytes
package sync_serial_pkg;

	// ------------------------------------------------------------
	// register byte offsets
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_ONE_OFS  = 8'h00;
	localparam logic [7:0] CTRL_TWO_OFS  = 8'h04;
	localparam logic [7:0] STATUS_OFS    = 8'h08;
	localparam logic [7:0] DBUF_BASE_OFS = 8'h20;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int RUN_BIT    = 7;
	localparam int ABORT_BIT  = 6;
	localparam int MODE_MSB   = 5;
	localparam int MODE_LSB   = 3;
	localparam int CLK_MSB    = 2;
	localparam int CLK_LSB    = 0;
	localparam int WCNT_MSB   = 2;
	localparam int WCNT_LSB   = 0;
	localparam int ACTIVE_BIT = 7;
	localparam int SHIFT_BIT  = 6;

	// ------------------------------------------------------------
	// reset values and encodings
	// ------------------------------------------------------------
	localparam logic [7:0] CTRL_ONE_RST = 8'h00;
	localparam logic [2:0] CTRL_TWO_RST = 3'h0;
	localparam logic [2:0] MODE_DUPLEX  = 3'h4;
	localparam logic [2:0] MODE_RX8     = 3'h5;
	localparam logic [2:0] MODE_RX4     = 3'h6;
	localparam logic [2:0] CLK_EXTERNAL = 3'h7;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int HCLK_PERIOD_NS = 4;
	localparam int SCK_HALF_NS    = 32;
	localparam int SCK_HALF_CYC   = (SCK_HALF_NS / HCLK_PERIOD_NS < 1) ? 1 : SCK_HALF_NS / HCLK_PERIOD_NS;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_SHIFT = 2'b01,
		ST_WAIT  = 2'b11
	} seq_state_t;

	function automatic logic is_rx_mode(input logic [2:0] m);
		return (m == MODE_RX8) || (m == MODE_RX4);
	endfunction

	function automatic logic mode_usable(input logic [2:0] m);
		return is_rx_mode(m) || (m == MODE_DUPLEX);
	endfunction

endpackage

// file: rtl/sync_serial_rx_duplex.sv
// synchronous serial unit: receive and full-duplex modes with an eight-word buffer
// assumes an AHB-Lite master; the serial clock pin is driven here or by the peripheral
`timescale 1ns/1ps

// Contract
// - with run set in receive mode, input bits shift in on serial clock
// - every completed word is moved into the next buffer register
// - after the selected word count arrives, a buffer-full pulse is raised
// - internal clock: serial clock halts while unread data would be overwritten
// - reading any buffer register releases the wait; leave unused ones alone
// - external clock: unread previous data blocks storing and cancels reception
// - run cleared in receive: finish word, store it, then drop active
// - abort stops at once, drops active, discards partial word
// - mode switch clears buffers; stop and read before switching
// - duplex: transmit on leading edges, sample on trailing edges
// - duplex: each 8-bit word is buffered; pulse after the count
// - internal clock duplex: wait until a transmit word is written
// - run cleared in duplex: buffer word, end after last bit, drop active
// - abort in duplex ends both directions at once, drops active
// - four-bit words fill low nibble, upper nibble received as zero
// - words go least significant bit first
// - burst length is one to eight words of four or eight bits
module sync_serial_rx_duplex import sync_serial_pkg::*; #(
	parameter int HALF_CYC = SCK_HALF_CYC
) (
	input  wire logic        hclk,             // bus clock, 250 MHz
	input  wire logic        hresetn,          // async reset, active low
	input  wire logic        hsel,             // slave select
	input  wire logic [31:0] haddr,            // byte address
	input  wire logic [1:0]  htrans,           // transfer type
	input  wire logic        hwrite,           // write not read
	input  wire logic [2:0]  hsize,            // word accesses only
	input  wire logic [31:0] hwdata,           // write data
	input  wire logic        hready,           // bus ready
	output logic      [31:0] hrdata,           // read data
	output logic             hreadyout,        // slave ready
	output logic             hresp,            // always okay
	input  wire logic        sck_i,            // serial clock pin level
	output logic             sck_o,            // serial clock drive value
	output logic             sck_oe_n,         // low while driving the clock pin
	input  wire logic        serial_in,        // serial data input pin
	output logic             serial_out_pin,   // serial data output pin
	output logic             serial_done_irq   // one-cycle burst complete pulse
);

	// ------------------------------------------------------------
	// register state
	// ------------------------------------------------------------
	logic             run;
	logic [2:0]       mode;
	logic [2:0]       clk_sel;
	logic [2:0]       word_cnt;
	logic [7:0]       dbuf [8];
	seq_state_t       state;
	logic [2:0]       bit_cnt;
	logic [2:0]       word_idx;
	logic [7:0]       rx_sh;
	logic             rd_seen;
	logic             wr_seen;
	logic             have_burst;
	logic             sck_int;
	logic [15:0]      div_cnt;
	logic             wr_pend;
	logic             rd_pend;
	logic [7:0]       addr_q;

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic sck_s;
	logic sck_rise;
	logic sck_fall;
	logic sin_s;

	pin_sync #(.RESET_LEVEL(1'b1)) u_sck_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.pin     (sck_i),
		.level   (sck_s),
		.rise    (sck_rise),
		.fall    (sck_fall)
	);

	pin_sync #(.RESET_LEVEL(1'b1)) u_sin_sync (
		.hclk    (hclk),
		.hresetn (hresetn),
		.pin     (serial_in),
		.level   (sin_s),
		.rise    (),
		.fall    ()
	);

	// ------------------------------------------------------------
	// bus decode
	// ------------------------------------------------------------
	wire       addr_take = hsel && hready && htrans[1];
	wire       sel_one   = (addr_q == CTRL_ONE_OFS);
	wire       sel_two   = (addr_q == CTRL_TWO_OFS);
	wire       sel_stat  = (addr_q == STATUS_OFS);
	wire       sel_dbuf  = (addr_q[7:5] == DBUF_BASE_OFS[7:5]) && (addr_q[1:0] == 2'b00);
	wire [2:0] dbuf_idx  = addr_q[4:2];
	wire       wr_one    = wr_pend && sel_one;
	wire       wr_two    = wr_pend && sel_two;
	wire       wr_dbuf   = wr_pend && sel_dbuf;
	wire       rd_dbuf   = rd_pend && sel_dbuf;
	wire [2:0] new_mode  = hwdata[MODE_MSB:MODE_LSB];
	wire       abort_req = wr_one && hwdata[ABORT_BIT];
	wire       mode_chg  = wr_one && (new_mode != mode);
	wire       start_req = wr_one && hwdata[RUN_BIT] && !abort_req && (state == ST_IDLE) && mode_usable(new_mode);

	wire       active   = (state != ST_IDLE);
	wire       shifting = (state == ST_SHIFT);
	wire [7:0] stat_val = {active, shifting, 6'h00};
	wire [7:0] one_val  = {run, 1'b0, mode, clk_sel};
	wire [7:0] reg_val  = sel_one  ? one_val :
	                      sel_two  ? {5'h00, word_cnt} :
	                      sel_stat ? stat_val :
	                      sel_dbuf ? dbuf[dbuf_idx] : 8'h00;

	// ------------------------------------------------------------
	// serial event decode
	// ------------------------------------------------------------
	wire       ext_clk   = (clk_sel == CLK_EXTERNAL);
	wire       duplex    = (mode == MODE_DUPLEX);
	wire       wide      = (mode != MODE_RX4);
	wire       tick      = shifting && !ext_clk && (div_cnt == 16'(HALF_CYC - 1));
	wire       lead_ev   = shifting && (ext_clk ? sck_fall : (tick && sck_int));
	wire       trail_ev  = shifting && (ext_clk ? sck_rise : (tick && !sck_int));
	wire       last_bit  = (bit_cnt == (wide ? 3'd7 : 3'd3));
	wire [7:0] next_sh   = {sin_s, rx_sh[7:1]};
	// four-bit words land right-aligned, upper nibble zero
	wire [7:0] rx_word   = wide ? next_sh : {4'h0, next_sh[7:4]};
	wire       word_done = trail_ev && last_bit;
	// word count field plus one words per burst
	wire       burst_end = word_done && (word_idx == word_cnt);
	// in receive any buffer read, in duplex only a transmit write, releases
	wire       released  = duplex ? wr_seen : rd_seen;
	// external clock: new burst over unread data is refused
	wire       blocked   = word_done && ext_clk && have_burst && (word_idx == 3'd0) && !released;
	wire       store     = word_done && !blocked && !abort_req;

	// ------------------------------------------------------------
	// AHB-Lite slave: writes zero-wait, reads one wait state
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend   <= 1'b0;
			rd_pend   <= 1'b0;
			addr_q    <= 8'h00;
			hreadyout <= 1'b1;
			hrdata    <= 32'h0000_0000;
			hresp     <= 1'b0;
		end else begin
			wr_pend   <= addr_take && hwrite;
			rd_pend   <= addr_take && !hwrite;
			hreadyout <= rd_pend || !(addr_take && !hwrite);
			if (addr_take) begin
				addr_q <= haddr[7:0];
			end
			if (rd_pend) begin
				hrdata <= {24'h00_0000, reg_val};
			end
		end
	end

	// ------------------------------------------------------------
	// control registers
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			run      <= CTRL_ONE_RST[RUN_BIT];
			mode     <= CTRL_ONE_RST[MODE_MSB:MODE_LSB];
			clk_sel  <= CTRL_ONE_RST[CLK_MSB:CLK_LSB];
			word_cnt <= CTRL_TWO_RST;
		end else begin
			if (wr_one) begin
				// abort also drops the run request
				run     <= hwdata[RUN_BIT] && !abort_req;
				mode    <= new_mode;
				clk_sel <= hwdata[CLK_MSB:CLK_LSB];
			end
			if (wr_two) begin
				word_cnt <= hwdata[WCNT_MSB:WCNT_LSB];
			end
		end
	end

	// ------------------------------------------------------------
	// data buffer
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 8; i++) begin
				dbuf[i] <= 8'h00;
			end
		end else if (mode_chg) begin
			// buffer contents do not survive a mode switch
			for (int i = 0; i < 8; i++) begin
				dbuf[i] <= 8'h00;
			end
		end else if (store) begin
			// completed word into next buffer slot
			dbuf[word_idx] <= rx_word;
		end else if (wr_dbuf) begin
			dbuf[dbuf_idx] <= hwdata[7:0];
		end
	end

	// ------------------------------------------------------------
	// service flags: the set wins over the burst-end clear
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			rd_seen    <= 1'b0;
			wr_seen    <= 1'b0;
			have_burst <= 1'b0;
		end else begin
			// a read of any buffer slot counts
			rd_seen    <= rd_dbuf || (rd_seen && !burst_end && !start_req);
			wr_seen    <= wr_dbuf || (wr_seen && !burst_end && !start_req);
			have_burst <= burst_end || (have_burst && !start_req);
		end
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state    <= ST_IDLE;
			bit_cnt  <= 3'd0;
			word_idx <= 3'd0;
			rx_sh    <= 8'h00;
		end else if (abort_req) begin
			// abort ends at once, partial word dropped
			state    <= ST_IDLE;
			bit_cnt  <= 3'd0;
			word_idx <= 3'd0;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (start_req) begin
						state    <= ST_SHIFT;
						bit_cnt  <= 3'd0;
						word_idx <= 3'd0;
					end
				end
				ST_SHIFT: begin
					if (trail_ev) begin
						rx_sh <= next_sh;
					end
					if (word_done) begin
						bit_cnt  <= 3'd0;
						word_idx <= burst_end ? 3'd0 : word_idx + 3'd1;
						if (blocked) begin
							state <= ST_IDLE;
						end else if (!run) begin
							// stop after the word that was in flight
							state <= ST_IDLE;
						end else if (burst_end && !ext_clk) begin
							state <= ST_WAIT;
						end
					end else if (trail_ev) begin
						bit_cnt <= bit_cnt + 3'd1;
					end
				end
				ST_WAIT: begin
					if (!run) begin
						state <= ST_IDLE;
					end else if (released) begin
						state <= ST_SHIFT;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// internal serial clock and pins
	// ------------------------------------------------------------
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_cnt  <= 16'h0000;
			sck_int  <= 1'b1;
			sck_o    <= 1'b1;
			sck_oe_n <= 1'b1;
		end else begin
			// clock idles high outside shifting; the divider restarts so a period is never cut short
			if (!shifting || ext_clk || tick || abort_req) begin
				div_cnt <= 16'h0000;
			end else begin
				div_cnt <= div_cnt + 16'h0001;
			end
			if (tick && !abort_req) begin
				sck_int <= !sck_int;
			end else if (!shifting || abort_req) begin
				sck_int <= 1'b1;
			end
			sck_o    <= (tick && !abort_req) ? !sck_int : ((shifting && !abort_req) ? sck_int : 1'b1);
			sck_oe_n <= ext_clk;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			serial_out_pin  <= 1'b1;
			serial_done_irq <= 1'b0;
		end else begin
			// transmit bit leaves on the leading edge
			if (lead_ev && duplex && !abort_req) begin
				serial_out_pin <= dbuf[word_idx][bit_cnt];
			end else if (state == ST_IDLE || abort_req) begin
				serial_out_pin <= 1'b1;
			end
			// pulse when the burst is complete
			serial_done_irq <= burst_end && !blocked && !abort_req;
		end
	end

endmodule

// file: tb/serial_peer.sv
// model of the external synchronous peripheral
// assumes the bench resolves the clock pin and feeds it back as sck_line
`timescale 1ns/1ps
module serial_peer (
	input  wire logic sck_line,       // resolved clock pin
	input  wire logic serial_out_pin, // data from the block
	output logic      serial_in,      // data to the block
	output logic      sck_ext         // clock when the peer drives it
);
	// ----------------------------------------
	// shift registers
	// ----------------------------------------
	logic [31:0] tx_bits;
	logic [7:0]  rx_byte;

	initial begin
		serial_in = 1'b1;
		sck_ext = 1'b1;
		tx_bits = 32'h0000_0000;
		rx_byte = 8'h00;
	end
	// send on leading edge
	// spent bits refill inverted so stale data never repeats
	always @(negedge sck_line) begin
		serial_in <= tx_bits[0];
		tx_bits <= {~tx_bits[0], tx_bits[31:1]};
	end
	always @(posedge sck_line) begin
		rx_byte <= {serial_out_pin, rx_byte[7:1]};
	end
	task automatic load(input logic [31:0] bits);
		tx_bits = bits;
	endtask
	// clock stands high between frames; offset keeps edges off hclk
	task automatic ext_burst(input int n);
		#1;
		repeat (n) begin
			#32 sck_ext = 1'b0;
			#32 sck_ext = 1'b1;
		end
	endtask
endmodule

// file: tb/sync_serial_properties.sv
// port-level checks for the serial receive/duplex block
// bound from the bench; hready there equals hreadyout
`timescale 1ns/1ps
module sync_serial_checker
	import sync_serial_pkg::*;
#(
	parameter int HALF_CYC = 8
) (
	input wire logic        hclk,           // clock
	input wire logic        hresetn,        // reset
	input wire logic        hsel,           // select
	input wire logic [31:0] haddr,          // address
	input wire logic [1:0]  htrans,         // type
	input wire logic        hwrite,         // write
	input wire logic [2:0]  hsize,          // size
	input wire logic [31:0] hwdata,         // wdata
	input wire logic        hready,         // ready in
	input wire logic [31:0] hrdata,         // rdata
	input wire logic        hreadyout,      // ready out
	input wire logic        hresp,          // resp
	input wire logic        sck_i,          // clock pin
	input wire logic        sck_o,          // clock drive
	input wire logic        sck_oe_n,       // drive enable
	input wire logic        serial_in,      // data in
	input wire logic        serial_out_pin, // data out
	input wire logic        serial_done_irq // done
);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	logic [4:0] low_cnt;
	logic [4:0] hi_cnt;
	logic       ctl_aph;
	logic       wr_done;
	logic       ext_q;
	logic       abort_q;
	wire        req      = hsel && hready && htrans[1];
	wire        ctl_req  = req && hwrite && (haddr[7:0] == CTRL_ONE_OFS);
	wire        ctl_data = ctl_aph && hready;

	// counters saturate so a stuck clock cannot wrap back into range
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			low_cnt <= 5'h00;
			hi_cnt  <= 5'h00;
			ctl_aph <= 1'b0;
			wr_done <= 1'b0;
			ext_q   <= 1'b0;
			abort_q <= 1'b0;
		end else begin
			low_cnt <= sck_o ? 5'h00 : ((low_cnt == 5'h1F) ? low_cnt : low_cnt + 5'h01);
			hi_cnt  <= !sck_o ? 5'h00 : ((hi_cnt == 5'h1F) ? hi_cnt : hi_cnt + 5'h01);
			ctl_aph <= hready ? ctl_req : ctl_aph;
			wr_done <= ctl_data;
			ext_q   <= ctl_data ? (hwdata[CLK_MSB:CLK_LSB] == CLK_EXTERNAL) : ext_q;
			abort_q <= ctl_data ? hwdata[ABORT_BIT] : abort_q;
		end
	end

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence s_rd_req;
		req && !hwrite;
	endsequence
	sequence s_rd_ans;
		!hreadyout ##1 hreadyout;
	endsequence
	property p_read_wait;
		s_rd_req |=> s_rd_ans;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read lacks its single wait state");
	property p_write_ready;
		req && hwrite |=> hreadyout;
	endproperty
	a_write_ready: assert property (p_write_ready) else $error("write was stalled");
	property p_unmapped_zero;
		req && !hwrite && haddr[7:0] == 8'h10 |-> ##2 hrdata == 32'h0000_0000;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero) else $error("unmapped read not zero");
	property p_okay;
		hresp == 1'b0;
	endproperty
	a_okay: assert property (p_okay) else $error("response not okay");
	property p_irq_pulse;
		serial_done_irq |=> !serial_done_irq;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("done pulse too long");
	property p_half_period;
		!sck_o && !sck_oe_n |-> low_cnt < HALF_CYC;
	endproperty
	a_half_period: assert property (p_half_period) else $error("clock low too long");
	property p_irq_after_rise;
		serial_done_irq && !sck_oe_n |-> sck_o && hi_cnt < 5'h06;
	endproperty
	a_irq_after_rise: assert property (p_irq_after_rise) else $error("done not after trailing edge");
	property p_wait_hold;
		$rose(serial_done_irq) && !sck_oe_n |-> sck_o [*4];
	endproperty
	a_wait_hold: assert property (p_wait_hold) else $error("clock not held in wait");
	property p_abort_stop;
		wr_done && abort_q |-> ##2 sck_o [*6];
	endproperty
	a_abort_stop: assert property (p_abort_stop) else $error("clock runs after abort");
	property p_ext_no_drive;
		wr_done && ext_q |-> ##2 sck_oe_n [*6];
	endproperty
	a_ext_no_drive: assert property (p_ext_no_drive) else $error("clock pin driven in external mode");
endmodule

// file: tb/tb_top.sv
// self-checking bench for the serial receive/duplex block
// assumes the peer model on the far side and the checker bound below
`timescale 1ns/1ps
module tb_top
	import sync_serial_pkg::*;
;
	logic        hclk = 1'b0;
	logic        hresetn, hsel, hwrite, hreadyout, hresp;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic        sck_o, sck_oe_n, serial_in, serial_out_pin, serial_done_irq, sck_ext;
	wire         sck_line = sck_oe_n ? sck_ext : sck_o;
	int          err_total, check_count, irq_total;
	logic [7:0]  addrs [5] = '{CTRL_ONE_OFS, CTRL_TWO_OFS, STATUS_OFS, DBUF_BASE_OFS, 8'h10};

	sync_serial_rx_duplex u_dut (
		.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .sck_i(sck_line), .sck_o,
		.sck_oe_n, .serial_in, .serial_out_pin, .serial_done_irq
	);
	serial_peer u_peer (.sck_line, .serial_out_pin, .serial_in, .sck_ext);

	always #2 hclk = ~hclk;
	always @(posedge hclk) if (serial_done_irq === 1'b1) irq_total <= irq_total + 1;

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		hsize <= 3'b010;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= {24'h00_0000, d};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 8'h00);
		chk(rd, exp);
	endtask
	task automatic wait_irq(input int n);
		@(posedge hclk);
		for (int i = 0; i < 4000 && irq_total < n; i++) @(posedge hclk);
		chk(irq_total, n);
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 100; i++) begin
			xfer(1'b0, STATUS_OFS, 8'h00);
			if (rd[ACTIVE_BIT] === 1'b0) break;
		end
		chk(rd, 32'h0000_0000);
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	initial begin
		#50000;
		err_total++;
		close_out();
	end

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		htrans = 2'b00;
		haddr = 32'h0000_0000;
		hwrite = 1'b0;
		hsize = 3'b000;
		hwdata = 32'h0000_0000;
		err_total = 0;
		check_count = 0;
		irq_total = 0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// reset values; the unmapped word ignores writes
		xfer(1'b1, 8'h10, 8'hFF);
		foreach (addrs[i]) rchk(addrs[i], 32'h0000_0000);
		// receive, internal clock: two words, one-word bursts after a count change, then a stop in mid-word
		u_peer.load(32'hC35A_3CA5);
		xfer(1'b1, CTRL_TWO_OFS, 8'h01);
		xfer(1'b1, CTRL_ONE_OFS, 8'hA8);
		wait_irq(1);
		xfer(1'b0, STATUS_OFS, 8'h00);
		chk(rd & 32'h0000_0080, 32'h0000_0080);
		xfer(1'b1, CTRL_TWO_OFS, 8'h00);
		rchk(DBUF_BASE_OFS, 32'h0000_00A5);
		rchk(8'h24, 32'h0000_003C);
		wait_irq(2);
		rchk(DBUF_BASE_OFS, 32'h0000_005A);
		xfer(1'b1, CTRL_ONE_OFS, 8'h28);
		wait_idle();
		chk(irq_total, 3);
		rchk(DBUF_BASE_OFS, 32'h0000_00C3);
		// four-bit receive, external clock; a second word while unread is refused
		u_peer.load(32'h0000_00FB);
		xfer(1'b1, CTRL_TWO_OFS, 8'h00);
		xfer(1'b1, CTRL_ONE_OFS, 8'hB7);
		u_peer.ext_burst(4);
		wait_irq(4);
		u_peer.ext_burst(4);
		repeat (40) @(posedge hclk);
		chk(irq_total, 4);
		wait_idle();
		rchk(DBUF_BASE_OFS, 32'h0000_000B);
		// duplex, internal clock, one word, then an abort in mid-word
		xfer(1'b1, CTRL_ONE_OFS, 8'h20);
		rchk(DBUF_BASE_OFS, 32'h0000_0000);
		u_peer.load(32'h0000_0069);
		xfer(1'b1, DBUF_BASE_OFS, 8'hC3);
		xfer(1'b1, CTRL_ONE_OFS, 8'hA0);
		wait_irq(5);
		chk({24'h00_0000, u_peer.rx_byte}, 32'h0000_00C3);
		rchk(DBUF_BASE_OFS, 32'h0000_0069);
		xfer(1'b1, DBUF_BASE_OFS, 8'h81);
		repeat (30) @(posedge hclk);
		xfer(1'b1, CTRL_ONE_OFS, 8'h60);
		rchk(STATUS_OFS, 32'h0000_0000);
		repeat (300) @(posedge hclk);
		chk(irq_total, 5);
		// duplex, external clock: buffers serviced between bursts
		xfer(1'b1, CTRL_ONE_OFS, 8'h27);
		xfer(1'b1, DBUF_BASE_OFS, 8'h5C);
		u_peer.load(32'h0000_E196);
		xfer(1'b1, CTRL_ONE_OFS, 8'hA7);
		u_peer.ext_burst(8);
		wait_irq(6);
		chk({24'h00_0000, u_peer.rx_byte}, 32'h0000_005C);
		rchk(DBUF_BASE_OFS, 32'h0000_0096);
		xfer(1'b1, DBUF_BASE_OFS, 8'hA1);
		u_peer.ext_burst(8);
		wait_irq(7);
		chk({24'h00_0000, u_peer.rx_byte}, 32'h0000_00A1);
		rchk(DBUF_BASE_OFS, 32'h0000_00E1);
		close_out();
	end
endmodule

bind sync_serial_rx_duplex sync_serial_checker #(.HALF_CYC(HALF_CYC)) u_chk (
	.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
	.hrdata, .hreadyout, .hresp, .sck_i, .sck_o, .sck_oe_n, .serial_in,
	.serial_out_pin, .serial_done_irq
);
